// File: rtl/sad_pkg.sv
package sad_pkg;

  // ----------------------------------------------------------------
  // Memory map bounds
  // ----------------------------------------------------------------
  localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] FLASH_LIMIT = 32'h07FF_FFFF;
  localparam logic [31:0] BOOT_BASE = 32'h1C00_0000;
  localparam logic [31:0] BOOT_LIMIT = 32'h1C00_1FFF;
  localparam logic [31:0] SRAM_L_END = 32'h1FFF_FFFF;
  localparam logic [31:0] SRAM_ANCHOR = 32'h2000_0000;
  localparam logic [31:0] PERIPH_BASE = 32'h4000_0000;
  localparam logic [31:0] PERIPH_LIMIT = 32'h4007_FFFF;
  localparam logic [31:0] GPIO_BASE = 32'h400F_F000;
  localparam logic [31:0] GPIO_LIMIT = 32'h400F_FFFF;
  localparam logic [31:0] BIT_BASE = 32'h4400_0000;
  localparam logic [31:0] BIT_LIMIT = 32'h5FFF_FFFF;
  localparam logic [31:0] PRIV_BASE = 32'hE000_0000;
  localparam logic [31:0] PRIV_LIMIT = 32'hE00F_FFFF;
  localparam logic [31:0] TRACE_BASE = 32'hF000_0000;
  localparam logic [31:0] DWT_BASE = 32'hF000_1000;
  localparam logic [31:0] ROMTBL_BASE = 32'hF000_2000;
  localparam logic [31:0] MISC_BASE = 32'hF000_3000;
  localparam logic [31:0] IO_BASE = 32'hF800_0000;
  localparam logic [31:0] REGION_4K_MASK = 32'h0000_0FFF;

  // ----------------------------------------------------------------
  // Field positions and sizes
  // ----------------------------------------------------------------
  localparam int SLOT_LSB = 12;
  localparam int SLOT_W = 7;
  localparam int SLOT_COUNT = 128;
  localparam logic [6:0] GPIO_SLOT = 7'h0F;
  localparam logic [31:0] VECTOR_BYTES = 32'h0000_00C4;
  localparam int KB_BYTES = 1024;
  localparam int RF_BYTES = 16;
  localparam int RF_WORDS = RF_BYTES / 4;
  localparam logic [31:0] RF_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TGT_NONE = 4'h0,
    TGT_FLASH = 4'h1,
    TGT_BOOT_ROM = 4'h2,
    TGT_SRAM_L = 4'h3,
    TGT_SRAM_U = 4'h4,
    TGT_PERIPH = 4'h5,
    TGT_GPIO = 4'h6,
    TGT_BIT_ENGINE = 4'h7,
    TGT_PRIVATE = 4'h8,
    TGT_TRACE = 4'h9,
    TGT_TRACE_DWT = 4'hA,
    TGT_ROM_TABLE = 4'hB,
    TGT_MISC_CTRL = 4'hC,
    TGT_IO_PORT = 4'hD
  } sad_target_t;

  typedef enum logic [2:0] {
    PM_RUN = 3'h0,
    PM_STOP = 3'h1,
    PM_RETENTION_STOP_LEVEL = 3'h2,
    PM_DEEP_STOP_LEVEL_ONE = 3'h3,
    PM_DEEP_STOP_LEVEL_ZERO = 3'h4
  } sad_pmode_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } sad_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic write;
    logic vector;
    sad_target_t target;
    logic [31:0] addr;
  } sad_resp_t;

endpackage

// File: rtl/sad_decoder.sv
`timescale 1ns/100ps

// What this block does
// (R1) SRAM split one quarter lower, three quarters upper
// (R2) Lower bank ends at 0x1FFF_FFFF
// (R3) Upper bank starts at 0x2000_0000
// (R4) Default size gives FE00 lower, 05FF upper
// (R5) SRAM range beyond capacity answers error
// (R6) Flash decodes from address zero, size-limited
// (R7) First 196 flash bytes are vectors
// (R8) Flash range beyond implemented size errors
// (R9) Bit engine alias routes to slots 0-127
// (R10) Bit engine alias also reaches GPIO slot
// (R11) Plain loads/stores trigger atomic engine operations; here they are only decoded to TGT_BIT_ENGINE, with no engine
// (R12) 0xF800_0000 upward selects single-cycle IO port
// (R13) 4 KB at 0xF000_0000 selects trace buffer
// (R14) 4 KB at 0xF000_3000 selects misc control
// (R15) 16-byte always-powered file survives voltage events
// (R16) Register file cleared only by power-on
// (R17) SRAM kept to retention level, lost deeper
// (R18) Full 32-bit byte address space decoded
// (R19) Reserved ranges answer error, no target
// (R20) Disabled or missing bridge slot answers error
module sad_decoder #(
  parameter int FLASH_KB = 32,
  parameter int SRAM_KB = 2
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic por_n_in,
  input wire sad_pkg::sad_req_t req_in,
  input wire logic [sad_pkg::SLOT_COUNT-1:0] slot_en_in,
  output sad_pkg::sad_resp_t resp_out,
  input wire sad_pkg::sad_pmode_t power_mode_in,
  input wire logic sram_init_done_in,
  output logic sram_retain_out,
  output logic sram_lost_out,
  input wire logic rf_wr_in,
  input wire logic [1:0] rf_idx_in,
  input wire logic [31:0] rf_wdata_in,
  output logic [31:0] rf_rdata_out
);

  // ----------------------------------------------------------------
  // Derived bounds
  // ----------------------------------------------------------------
  // Implemented flash and SRAM bytes
  localparam logic [31:0] FLASH_BYTES = 32'(FLASH_KB * sad_pkg::KB_BYTES);
  localparam logic [31:0] SRAM_BYTES = 32'(SRAM_KB * sad_pkg::KB_BYTES);
  // Last implemented flash byte
  localparam logic [31:0] FLASH_END = sad_pkg::FLASH_BASE + FLASH_BYTES
    - 32'h0000_0001;
  // Lower bank start, a quarter below the anchor
  localparam logic [31:0] SRAM_L_START = sad_pkg::SRAM_ANCHOR
    - (SRAM_BYTES >> 2);
  // Upper bank end, three quarters above the anchor
  localparam logic [31:0] SRAM_U_END = sad_pkg::SRAM_ANCHOR
    + ((SRAM_BYTES >> 2) * 32'h0000_0003) - 32'h0000_0001;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Inclusive range test
  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Same 4 KB region as a base
  function automatic logic in_4k(input logic [31:0] a,
                                 input logic [31:0] base);
    in_4k = (a & ~sad_pkg::REGION_4K_MASK) == base;
  endfunction

  // Bridge slot index of a bridge or alias address
  function automatic logic [6:0] slot_of(input logic [31:0] a);
    slot_of = a[sad_pkg::SLOT_LSB +: sad_pkg::SLOT_W];
  endfunction

  // Target of an address, TGT_NONE for holes
  function automatic sad_pkg::sad_target_t decode(input logic [31:0] a);
    decode = sad_pkg::TGT_NONE;
    // Flash only up to the implemented size
    if (in_range(a, sad_pkg::FLASH_BASE, FLASH_END)) begin // [R6] [R8]
      decode = sad_pkg::TGT_FLASH;
    end else if (in_range(a, sad_pkg::BOOT_BASE, sad_pkg::BOOT_LIMIT)) begin
      decode = sad_pkg::TGT_BOOT_ROM;
    // Lower bank sits just under the anchor
    end else if (in_range(a, SRAM_L_START, sad_pkg::SRAM_L_END)) begin
      decode = sad_pkg::TGT_SRAM_L; // [R1] [R2] [R4] [R5]
    // Upper bank starts at the anchor
    end else if (in_range(a, sad_pkg::SRAM_ANCHOR, SRAM_U_END)) begin
      decode = sad_pkg::TGT_SRAM_U; // [R1] [R3] [R4] [R5]
    end else if (in_range(a, sad_pkg::PERIPH_BASE,
                          sad_pkg::PERIPH_LIMIT)) begin
      decode = sad_pkg::TGT_PERIPH;
    end else if (in_range(a, sad_pkg::GPIO_BASE, sad_pkg::GPIO_LIMIT)) begin
      decode = sad_pkg::TGT_GPIO;
    // Decorated alias of slots 0-127, GPIO slot included
    end else if (in_range(a, sad_pkg::BIT_BASE, sad_pkg::BIT_LIMIT)) begin
      decode = sad_pkg::TGT_BIT_ENGINE; // [R9] [R10] [R11]
    end else if (in_range(a, sad_pkg::PRIV_BASE, sad_pkg::PRIV_LIMIT)) begin
      decode = sad_pkg::TGT_PRIVATE;
    end else if (in_4k(a, sad_pkg::TRACE_BASE)) begin
      decode = sad_pkg::TGT_TRACE; // [R13]
    end else if (in_4k(a, sad_pkg::DWT_BASE)) begin
      decode = sad_pkg::TGT_TRACE_DWT;
    end else if (in_4k(a, sad_pkg::ROMTBL_BASE)) begin
      decode = sad_pkg::TGT_ROM_TABLE;
    end else if (in_4k(a, sad_pkg::MISC_BASE)) begin
      decode = sad_pkg::TGT_MISC_CTRL; // [R14]
    // Top of the space up to the last byte
    end else if (a >= sad_pkg::IO_BASE) begin
      decode = sad_pkg::TGT_IO_PORT; // [R12] [R18]
    end
  endfunction

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  sad_pkg::sad_target_t next_target; // Raw decode of request
  logic next_slot_ok; // Bridge slot present and clocked
  logic next_err; // Request ends in error

  // Target pick and error terms
  always_comb begin
    next_target = decode(req_in.addr);
    next_slot_ok = 1'b1;
    unique case (next_target)
      // Bridge and alias follow the slot enables
      sad_pkg::TGT_PERIPH,
      sad_pkg::TGT_BIT_ENGINE: begin
        next_slot_ok = slot_en_in[slot_of(req_in.addr)]; // [R20]
      end
      // GPIO window is slot 15 seen directly
      sad_pkg::TGT_GPIO: begin
        next_slot_ok = slot_en_in[sad_pkg::GPIO_SLOT]; // [R20]
      end
      // Everything else has no slot gate
      default: begin
        next_slot_ok = 1'b1;
      end
    endcase
    // Holes and beyond-size ranges terminate with error
    next_err = (next_target == sad_pkg::TGT_NONE) || !next_slot_ok; // [R19]
  end

  // ----------------------------------------------------------------
  // Data phase response
  // ----------------------------------------------------------------
  // Registered answer one cycle after the request
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resp_out <= '0;
    end else begin
      resp_out.valid <= req_in.valid;
      resp_out.write <= req_in.write;
      resp_out.addr <= req_in.addr;
      // Error answers carry no target
      if (req_in.valid && !next_err) begin
        resp_out.target <= next_target;
        resp_out.err <= 1'b0;
      end else begin
        resp_out.target <= sad_pkg::TGT_NONE;
        resp_out.err <= req_in.valid; // [R5] [R8] [R19] [R20]
      end
      // Flag fetches from the vector table
      resp_out.vector <= req_in.valid && !next_err &&
        (req_in.addr < sad_pkg::VECTOR_BYTES); // [R7]
    end
  end

  // ----------------------------------------------------------------
  // SRAM retention
  // ----------------------------------------------------------------
  logic deep_mode; // Leakage stop levels drop SRAM

  // Deepest levels lose contents
  always_comb begin
    deep_mode = (power_mode_in == sad_pkg::PM_DEEP_STOP_LEVEL_ONE) ||
                (power_mode_in == sad_pkg::PM_DEEP_STOP_LEVEL_ZERO);
  end

  // Retention supply kept down to retention level
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sram_retain_out <= 1'b1;
    end else begin
      sram_retain_out <= !deep_mode; // [R17]
    end
  end

  // Sticky loss flag, loss beats init done
  always_ff @(posedge core_clk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      sram_lost_out <= 1'b1;
    end else if (deep_mode) begin
      sram_lost_out <= 1'b1; // [R17]
    end else if (sram_init_done_in) begin
      sram_lost_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Always-powered register file
  // ----------------------------------------------------------------
  logic [sad_pkg::RF_WORDS-1:0][31:0] rf_mem; // Four retained words

  // Only power-on clears; system reset does not
  always_ff @(posedge core_clk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      rf_mem <= {sad_pkg::RF_WORDS{sad_pkg::RF_RESET}}; // [R16]
    end else if (rf_wr_in) begin
      rf_mem[rf_idx_in] <= rf_wdata_in; // [R15]
    end
  end

  // Registered read of the addressed word
  always_ff @(posedge core_clk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      rf_rdata_out <= sad_pkg::RF_RESET;
    end else begin
      rf_rdata_out <= rf_mem[rf_idx_in];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_flash_beyond;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    req_in.valid && (req_in.addr > FLASH_END) &&
    (req_in.addr <= sad_pkg::FLASH_LIMIT)
    |=> resp_out.err && (resp_out.target == sad_pkg::TGT_NONE);
  endproperty
  a_flash_beyond: assert property (p_flash_beyond) // [R8]
    else $error("flash beyond size not errored");

  property p_flash_in;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    req_in.valid && (req_in.addr <= FLASH_END)
    |=> !resp_out.err && (resp_out.target == sad_pkg::TGT_FLASH);
  endproperty
  a_flash_in: assert property (p_flash_in) // [R6]
    else $error("flash address not routed to flash");

  property p_vector;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    resp_out.vector |-> $past(req_in.addr) < sad_pkg::VECTOR_BYTES;
  endproperty
  a_vector: assert property (p_vector) // [R7]
    else $error("vector flag outside table");

  property p_sram_l;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    req_in.valid && (req_in.addr >= SRAM_L_START) &&
    (req_in.addr <= sad_pkg::SRAM_L_END)
    |=> resp_out.target == sad_pkg::TGT_SRAM_L;
  endproperty
  a_sram_l: assert property (p_sram_l) // [R2]
    else $error("lower bank not selected");

  property p_sram_u;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    req_in.valid && (req_in.addr >= sad_pkg::SRAM_ANCHOR) &&
    (req_in.addr <= SRAM_U_END)
    |=> resp_out.target == sad_pkg::TGT_SRAM_U;
  endproperty
  a_sram_u: assert property (p_sram_u) // [R3]
    else $error("upper bank not selected");

  property p_sram_edges;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    req_in.valid && ((req_in.addr == SRAM_U_END + 32'h0000_0001) ||
    (req_in.addr == SRAM_L_START - 32'h0000_0001))
    |=> resp_out.err;
  endproperty
  a_sram_edges: assert property (p_sram_edges) // [R5]
    else $error("access past SRAM not errored");

  property p_slot_off;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    req_in.valid && (req_in.addr >= sad_pkg::BIT_BASE) &&
    (req_in.addr <= sad_pkg::BIT_LIMIT) &&
    !slot_en_in[slot_of(req_in.addr)]
    |=> resp_out.err && (resp_out.target == sad_pkg::TGT_NONE);
  endproperty
  a_slot_off: assert property (p_slot_off) // [R20]
    else $error("disabled slot not errored");

  property p_bit_gpio;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    req_in.valid && (req_in.addr >= sad_pkg::BIT_BASE) &&
    (req_in.addr <= sad_pkg::BIT_LIMIT) &&
    (slot_of(req_in.addr) == sad_pkg::GPIO_SLOT) &&
    slot_en_in[sad_pkg::GPIO_SLOT]
    |=> resp_out.target == sad_pkg::TGT_BIT_ENGINE;
  endproperty
  a_bit_gpio: assert property (p_bit_gpio) // [R10]
    else $error("alias of GPIO slot not routed");

  property p_io_port;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    req_in.valid && (req_in.addr >= sad_pkg::IO_BASE)
    |=> !resp_out.err && (resp_out.target == sad_pkg::TGT_IO_PORT);
  endproperty
  a_io_port: assert property (p_io_port) // [R12]
    else $error("IO port not selected");

  property p_trace_misc;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (resp_out.target == sad_pkg::TGT_TRACE ||
     resp_out.target == sad_pkg::TGT_MISC_CTRL)
    |-> $past(req_in.addr[31:12]) ==
        ((resp_out.target == sad_pkg::TGT_TRACE) ?
         sad_pkg::TRACE_BASE[31:12] : sad_pkg::MISC_BASE[31:12]);
  endproperty
  a_trace_misc: assert property (p_trace_misc) // [R13] [R14]
    else $error("trace or control window misdecoded");

  property p_reserved;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    req_in.valid && (req_in.addr > sad_pkg::FLASH_LIMIT) &&
    (req_in.addr < sad_pkg::BOOT_BASE)
    |=> resp_out.err && (resp_out.target == sad_pkg::TGT_NONE);
  endproperty
  a_reserved: assert property (p_reserved) // [R19]
    else $error("reserved range not errored");

  property p_sram_lost;
    @(posedge core_clk_in) disable iff (!por_n_in || !rst_n_in)
    deep_mode |=> sram_lost_out && !sram_retain_out [*1];
  endproperty
  a_sram_lost: assert property (p_sram_lost) // [R17]
    else $error("deep stop did not drop SRAM");

  property p_rf_hold;
    @(posedge core_clk_in) disable iff (!por_n_in)
    !rf_wr_in |=> $stable(rf_mem);
  endproperty
  a_rf_hold: assert property (p_rf_hold) // [R16]
    else $error("register file changed without write");

endmodule // sad_decoder

// File: bench/sad_core_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Core bus master stand-in: puts one request or one idle cycle on the bus per call
// ------------------------------------------------------------------
module sad_core_model (
  output sad_pkg::sad_req_t req_out
);
  // Last address driven on the bus, idle cycles included
  logic [31:0] last_addr;

  // Bus idles with nothing requested
  initial begin
    req_out = '0;
    last_addr = 32'h0000_0000;
  end

  // One cycle of bus activity; idle cycles scramble the address lines
  task automatic put(input logic v, input logic w, input logic [31:0] a);
    if (v) begin
      req_out = {1'b1, w, a};
      last_addr = a;
    end else begin
      // Released bus must not look like a stale request
      req_out = {1'b0, ~req_out.write, ~last_addr};
      last_addr = ~last_addr;
    end
  endtask
endmodule // sad_core_model

// File: bench/system_address_decoder_bench.sv
`timescale 1ns/100ps

module system_address_decoder_bench;
  // ----------------------------------------------------------------
  // Sizes and derived bounds
  // ----------------------------------------------------------------
  localparam int FLASH_KB = 32;
  localparam int SRAM_KB = 2;
  localparam logic [31:0] FLASH_END = 32'(FLASH_KB * 1024);
  localparam logic [31:0] LOW_START = 32'h2000_0000 - 32'(SRAM_KB * 256);
  localparam logic [31:0] UP_END = 32'h2000_0000 + 32'(SRAM_KB * 768);

  // ----------------------------------------------------------------
  // Design connections and bench state
  // ----------------------------------------------------------------
  logic core_clk_in;
  logic rst_n_in;
  logic por_n_in;
  sad_pkg::sad_req_t req_in;
  logic [127:0] slot_en_in;
  sad_pkg::sad_resp_t resp_out;
  sad_pkg::sad_pmode_t power_mode_in;
  logic sram_init_done_in;
  logic sram_retain_out;
  logic sram_lost_out;
  logic rf_wr_in;
  logic [1:0] rf_idx_in;
  logic [31:0] rf_wdata_in;
  logic [31:0] rf_rdata_out;
  int bad_count;
  int check_count;
  logic pend_v; // Request awaiting its answer
  sad_pkg::sad_resp_t pend_exp; // Answer expected for it
  logic [31:0] rf_copy [4]; // Words written to the file
  logic exp_lost; // Expected lost flag
  logic [31:0] bases [14]; // Region starts for random traffic
  logic [31:0] seed_dummy;
  logic [31:0] ra;

  sad_decoder #(.FLASH_KB(FLASH_KB), .SRAM_KB(SRAM_KB)) u_sad_decoder (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
    .req_in(req_in), .slot_en_in(slot_en_in), .resp_out(resp_out),
    .power_mode_in(power_mode_in), .sram_init_done_in(sram_init_done_in),
    .sram_retain_out(sram_retain_out), .sram_lost_out(sram_lost_out),
    .rf_wr_in(rf_wr_in), .rf_idx_in(rf_idx_in), .rf_wdata_in(rf_wdata_in),
    .rf_rdata_out(rf_rdata_out));

  sad_core_model u_sad_core_model (.req_out(req_in));

  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  // Free-running 20 MHz clock
  always #25 core_clk_in = ~core_clk_in;

  // Compare and count
  task automatic check_val(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected answer for one request
  function automatic sad_pkg::sad_resp_t exp_resp(input logic w,
      input logic [31:0] a, input logic [127:0] en);
    sad_pkg::sad_target_t t;
    logic vec;
    t = sad_pkg::TGT_NONE;
    if (a < FLASH_END) t = sad_pkg::TGT_FLASH;
    else if (a >= 32'h1C00_0000 && a <= 32'h1C00_1FFF) t = sad_pkg::TGT_BOOT_ROM;
    else if (a >= LOW_START && a <= 32'h1FFF_FFFF) t = sad_pkg::TGT_SRAM_L;
    else if (a >= 32'h2000_0000 && a < UP_END) t = sad_pkg::TGT_SRAM_U;
    else if (a >= 32'h4000_0000 && a <= 32'h4007_FFFF) begin
      if (en[a[18:12]]) t = sad_pkg::TGT_PERIPH;
    end else if (a >= 32'h400F_F000 && a <= 32'h400F_FFFF) begin
      if (en[15]) t = sad_pkg::TGT_GPIO;
    end else if (a >= 32'h4400_0000 && a <= 32'h5FFF_FFFF) begin
      if (en[a[18:12]]) t = sad_pkg::TGT_BIT_ENGINE;
    end else if (a >= 32'hE000_0000 && a <= 32'hE00F_FFFF) t = sad_pkg::TGT_PRIVATE;
    else if (a[31:12] == 20'hF0000) t = sad_pkg::TGT_TRACE;
    else if (a[31:12] == 20'hF0001) t = sad_pkg::TGT_TRACE_DWT;
    else if (a[31:12] == 20'hF0002) t = sad_pkg::TGT_ROM_TABLE;
    else if (a[31:12] == 20'hF0003) t = sad_pkg::TGT_MISC_CTRL;
    else if (a >= 32'hF800_0000) t = sad_pkg::TGT_IO_PORT;
    vec = (t == sad_pkg::TGT_FLASH) && (a < 32'h0000_00C4);
    return {1'b1, t == sad_pkg::TGT_NONE, w, vec, t, a};
  endfunction

  // One bus cycle; the answer to the previous one is checked first
  task automatic step(input logic v, input logic w, input logic [31:0] a);
    @(negedge core_clk_in);
    if (pend_v) check_val(64'(resp_out), 64'(pend_exp));
    else check_val(64'(resp_out.valid), 64'h0);
    u_sad_core_model.put(v, w, a);
    pend_v = v;
    pend_exp = exp_resp(w, a, slot_en_in);
  endtask

  // Power mode change, then retention outputs one edge later
  task automatic mode_step(input int m, input logic init);
    logic deep;
    @(negedge core_clk_in);
    power_mode_in = sad_pkg::sad_pmode_t'(3'(m));
    sram_init_done_in = init;
    deep = (m == 3) || (m == 4);
    if (deep) exp_lost = 1'b1;
    else if (init) exp_lost = 1'b0;
    @(negedge core_clk_in);
    sram_init_done_in = 1'b0;
    check_val(64'(sram_retain_out), 64'(!deep));
    check_val(64'(sram_lost_out), 64'(exp_lost));
  endtask

  // Register file write, strobe lowered on the following cycle
  task automatic rf_write(input logic [1:0] i, input logic [31:0] d);
    @(negedge core_clk_in);
    rf_wr_in = 1'b1;
    rf_idx_in = i;
    rf_wdata_in = d;
    @(negedge core_clk_in);
    rf_wr_in = 1'b0;
  endtask

  // Register file read, data one edge after the index
  task automatic rf_read(input logic [1:0] i, input logic [31:0] e);
    @(negedge core_clk_in);
    rf_idx_in = i;
    @(negedge core_clk_in);
    check_val(64'(rf_rdata_out), 64'(e));
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    #(50 * 20000);
    bad_count++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    rst_n_in = 1'b0;
    por_n_in = 1'b0;
    slot_en_in = '1;
    power_mode_in = sad_pkg::PM_RUN;
    sram_init_done_in = 1'b0;
    rf_wr_in = 1'b0;
    rf_idx_in = 2'h0;
    rf_wdata_in = 32'h0000_0000;
    bad_count = 0;
    check_count = 0;
    pend_v = 1'b0;
    exp_lost = 1'b1;
    bases = '{32'h0000_0000, 32'h0000_7000, 32'h1C00_1000, 32'h1FFF_F000,
      32'h2000_0000, 32'h4000_0000, 32'h4007_F000, 32'h400F_F000,
      32'h4400_0000, 32'h5FFF_F000, 32'hE00F_F000, 32'hF000_0000,
      32'hF000_3000, 32'hF800_0000};
    seed_dummy = $urandom(54790);
    repeat (2) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    por_n_in = 1'b1;
    // Power-on state, then every power mode in turn
    for (int i = 0; i < 4; i++) rf_read(2'(i), 32'h0000_0000);
    for (int m = 0; m < 5; m++) mode_step(m, 1'b0);
    mode_step(0, 1'b1);
    mode_step(2, 1'b0);
    mode_step(4, 1'b1);
    mode_step(1, 1'b1);
    // File keeps data through deep stop level zero and a system reset
    for (int i = 0; i < 4; i++) begin
      rf_copy[i] = $urandom;
      rf_write(2'(i), rf_copy[i]);
    end
    mode_step(4, 1'b0);
    mode_step(0, 1'b1);
    @(negedge core_clk_in);
    rst_n_in = 1'b0;
    @(negedge core_clk_in);
    rst_n_in = 1'b1;
    for (int i = 0; i < 4; i++) rf_read(2'(i), rf_copy[i]);
    @(negedge core_clk_in);
    por_n_in = 1'b0;
    @(negedge core_clk_in);
    por_n_in = 1'b1;
    exp_lost = 1'b1;
    mode_step(0, 1'b0);
    for (int i = 0; i < 4; i++) rf_read(2'(i), 32'h0000_0000);
    // Decode corners, back to back
    step(1, 0, 32'h0000_0000);
    step(1, 0, 32'h0000_00C3);
    step(1, 0, 32'h0000_00C4);
    step(1, 0, 32'h0000_7FFF);
    step(1, 1, 32'h0000_8000);
    step(1, 0, 32'h07FF_FFFF);
    step(1, 0, 32'h1FFF_FDFF);
    step(1, 0, 32'h1FFF_FE00);
    step(1, 1, 32'h1FFF_FFFF);
    step(1, 0, 32'h2000_0000);
    step(1, 1, 32'h2000_05FF);
    step(1, 0, 32'h2000_0600);
    step(1, 0, 32'h1C00_2000);
    step(1, 0, 32'h4400_F004);
    step(1, 1, 32'h4400_F004);
    step(1, 0, 32'h5FFF_FFFF);
    step(1, 0, 32'h6000_0000);
    step(1, 0, 32'hF000_0FFF);
    step(1, 0, 32'hF000_3000);
    step(1, 0, 32'hF000_4000);
    step(1, 0, 32'hF800_0000);
    step(1, 1, 32'hFFFF_FFFF);
    step(0, 0, 32'h0000_0000);
    // Gated slots refuse, also through the alias
    slot_en_in[15] = 1'b0;
    slot_en_in[5] = 1'b0;
    step(1, 0, 32'h400F_F010);
    step(1, 1, 32'h4400_F000);
    step(1, 0, 32'h4000_5000);
    step(1, 0, 32'h4000_6000);
    // Random traffic over all regions with random slot gating
    for (int n = 0; n < 400; n++) begin
      // Gating changes only behind an idle cycle, so no open request sees it
      if (n % 32 == 0) begin
        step(0, 0, 32'h0000_0000);
        slot_en_in = {$urandom, $urandom, $urandom, $urandom};
      end
      ra = bases[$urandom % 14] + ($urandom & 32'h0000_1FFF);
      if ($urandom % 8 == 0) ra = $urandom;
      step(($urandom % 4) != 0, 1'($urandom), ra);
    end
    step(0, 0, 32'h0000_0000);
    end_sim();
  end
endmodule // system_address_decoder_bench
